// *** hdl/rasn_regs.svh ***
// constants for the error reporting node: widths, control and feature fields, resets
`ifndef RASN_REGS_SVH
`define RASN_REGS_SVH

`define RASN_NUM_REC   2
`define RASN_REC_W     1
`define RASN_SYN_W     16
`define RASN_TS_W      32

// control register fields
`define RASN_CTL_ED      0
`define RASN_CTL_ERI_RD  1
`define RASN_CTL_ERI_WR  2
`define RASN_CTL_DUI     3
`define RASN_CTL_CI      4
`define RASN_CTL_RSP_RD  5
`define RASN_CTL_RSP_WR  6
`define RASN_CTL_W       7
`define RASN_CTL_RST     7'h00

// implemented feature set, one bit per feature
`define RASN_FEAT_ED     1'b1
`define RASN_FEAT_ERI    1'b1
`define RASN_FEAT_DUI    1'b1
`define RASN_FEAT_CI     1'b1
`define RASN_FEAT_RSP    1'b1
`define RASN_FEAT_TS     1'b1
`define RASN_FEAT_RW     1'b1

// feature id register fields
`define RASN_ID_W        8
`define RASN_ID_TS       7

`endif

// *** hdl/rasn_pkg.sv ***
// types shared by the error reporting node
`include "rasn_regs.svh"
package rasn_pkg;

  typedef enum logic [1:0] {
    RASN_SEV_NONE = 2'h0,
    RASN_SEV_CE   = 2'h1,
    RASN_SEV_DE   = 2'h2,
    RASN_SEV_UE   = 2'h3
  } rasn_sev_t;

  typedef struct packed {
    logic                    valid;
    logic                    consumed;
    logic                    to_consumer;
    logic                    write;
    logic                    critical;
    rasn_sev_t               sev;
    logic [`RASN_REC_W-1:0]  rec;
    logic [`RASN_SYN_W-1:0]  syndrome;
  } rasn_err_t;

  typedef struct packed {
    logic                    valid;
    logic                    ovf;
    logic                    consumed;
    logic                    write;
    logic                    critical;
    rasn_sev_t               sev;
    logic [`RASN_SYN_W-1:0]  syndrome;
    logic [`RASN_TS_W-1:0]   stamp;
  } rasn_rec_t;

  typedef struct packed {
    logic valid;
    logic abort;
  } rasn_resp_t;

endpackage

// *** hdl/rasn_node.sv ***
// error reporting node: records, shared controls, in-band response and interrupts
`timescale 1ns/1ps
`default_nettype none
`include "rasn_regs.svh"

module rasn_node (
  input  wire logic                     clock,
  input  wire logic                     arst_n,
  input  wire rasn_pkg::rasn_err_t      err_in,
  input  wire logic                     ctl_load,
  input  wire logic [`RASN_CTL_W-1:0]   ctl_data,
  input  wire logic [`RASN_REC_W-1:0]   rec_rd_idx,
  input  wire logic                     rec_clr,
  input  wire logic [`RASN_REC_W-1:0]   rec_clr_idx,
  output var  logic [`RASN_CTL_W-1:0]   node_control_reg,
  output var  logic [`RASN_ID_W-1:0]    node_feature_id_reg,
  output var  rasn_pkg::rasn_rec_t      rec_rd_data,
  output var  rasn_pkg::rasn_resp_t     resp,
  output var  logic                     eri_irq,
  output var  logic                     crit_irq
);

  // unimplemented control bits read as zero
  localparam logic [`RASN_CTL_W-1:0] CTL_MASK = {
    `RASN_FEAT_RSP & `RASN_FEAT_RW,
    `RASN_FEAT_RSP,
    `RASN_FEAT_CI,
    `RASN_FEAT_ERI & `RASN_FEAT_DUI,
    `RASN_FEAT_ERI & `RASN_FEAT_RW,
    `RASN_FEAT_ERI,
    `RASN_FEAT_ED
  };

  localparam logic [`RASN_ID_W-1:0] ID_VALUE = {
    `RASN_FEAT_TS,
    CTL_MASK
  };

  rasn_pkg::rasn_rec_t            recs_reg [`RASN_NUM_REC];
  logic [`RASN_TS_W-1:0]          stamp_reg;
  logic                           accept;
  logic                           to_abort;
  logic                           eri_next;
  logic                           crit_next;
  logic [`RASN_CTL_W-1:0]         ctl_next;
  logic [`RASN_TS_W-1:0]          stamp_cap;
  logic [`RASN_NUM_REC-1:0]       hit_vec;
  logic [`RASN_NUM_REC-1:0]       clr_vec;
  logic [`RASN_NUM_REC-1:0]       eri_vec;
  logic [`RASN_NUM_REC-1:0]       crit_vec;
  logic                           rsp_en;
  rasn_pkg::rasn_resp_t           resp_next;

  // path enable for a transfer direction; joint control uses the read bit
  function automatic logic dir_en(
    input logic [`RASN_CTL_W-1:0] ctl,
    input logic                   wr,
    input int unsigned            rd_bit,
    input int unsigned            wr_bit
  );
    logic en;
    en = ctl[rd_bit];
    if (`RASN_FEAT_RW && wr) begin
      en = ctl[wr_bit];
    end
    return en;
  endfunction

  // does a stored record hold the recovery interrupt
  function automatic logic eri_qual(
    input logic [`RASN_CTL_W-1:0] ctl,
    input rasn_pkg::rasn_rec_t    r
  );
    logic q;
    q = 1'b0;
    unique case (r.sev)
      rasn_pkg::RASN_SEV_UE: begin
        q = 1'b1;
      end
      rasn_pkg::RASN_SEV_DE: begin
        q = `RASN_FEAT_DUI & ctl[`RASN_CTL_DUI];
      end
      rasn_pkg::RASN_SEV_CE: begin
        q = 1'b0;
      end
      rasn_pkg::RASN_SEV_NONE: begin
        q = 1'b0;
      end
    endcase
    return r.valid & q & `RASN_FEAT_ERI
         & dir_en(ctl, r.write, `RASN_CTL_ERI_RD, `RASN_CTL_ERI_WR);
  endfunction

  // does an index select record i
  function automatic logic rec_sel(
    input logic [`RASN_REC_W-1:0] idx,
    input int unsigned            i
  );
    return idx == `RASN_REC_W'(i);
  endfunction

  // enables for implemented features
  // unimplemented enables are dropped at load so they can never gate a path
  always_comb begin
    ctl_next = node_control_reg;
    if (ctl_load) begin
      ctl_next = ctl_data & CTL_MASK;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      node_control_reg <= `RASN_CTL_RST;
    end else begin
      node_control_reg <= ctl_next;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      node_feature_id_reg <= {`RASN_ID_W{1'b0}};
    end else begin
      node_feature_id_reg <= ID_VALUE;
    end
  end

  // free-running time base; wraps silently, software must allow for that
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stamp_reg <= {`RASN_TS_W{1'b0}};
    end else begin
      stamp_reg <= stamp_reg + `RASN_TS_W'(1);
    end
  end

  always_comb begin
    accept = err_in.valid
           & (err_in.sev != rasn_pkg::RASN_SEV_NONE)
           & (node_control_reg[`RASN_CTL_ED] | ~`RASN_FEAT_ED);
  end

  // per-record capture and acknowledge strobes
  always_comb begin
    hit_vec = '0;
    clr_vec = '0;
    for (int i = 0; i < `RASN_NUM_REC; i++) begin
      hit_vec[i] = accept & rec_sel(err_in.rec, i);
      // set wins: an acknowledge meeting a capture is dropped, so no error is lost
      clr_vec[i] = rec_clr & rec_sel(rec_clr_idx, i) & ~hit_vec[i];
    end
  end

  // optional timestamp
  // without the feature the field stays zero rather than holding stale counts
  always_comb begin
    stamp_cap = '0;
    if (`RASN_FEAT_TS) begin
      stamp_cap = stamp_reg;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `RASN_NUM_REC; i++) begin
        recs_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < `RASN_NUM_REC; i++) begin
        if (hit_vec[i]) begin
          // a new error overwrites; ovf keeps the fact that one was lost
          recs_reg[i].valid    <= 1'b1;
          recs_reg[i].ovf      <= recs_reg[i].valid;
          recs_reg[i].consumed <= err_in.consumed;
          recs_reg[i].write    <= err_in.write;
          recs_reg[i].critical <= err_in.critical;
          recs_reg[i].sev      <= err_in.sev;
          recs_reg[i].syndrome <= err_in.syndrome;
          recs_reg[i].stamp    <= stamp_cap;
        end else if (clr_vec[i]) begin
          // capture above wins over a same-cycle acknowledge
          recs_reg[i].valid <= 1'b0;
          recs_reg[i].ovf   <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rec_rd_data <= '0;
    end else begin
      rec_rd_data <= recs_reg[rec_rd_idx];
    end
  end

  always_comb begin
    rsp_en = `RASN_FEAT_RSP
           & dir_en(node_control_reg, err_in.write, `RASN_CTL_RSP_RD, `RASN_CTL_RSP_WR);
  end

  always_comb begin
    to_abort = err_in.valid
             & err_in.to_consumer
             & (err_in.sev == rasn_pkg::RASN_SEV_UE)
             & rsp_en;
  end

  // response ignores the recording enable; consumers must still be told
  always_comb begin
    resp_next.valid = err_in.valid & err_in.to_consumer;
    resp_next.abort = to_abort;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      resp <= '0;
    end else begin
      resp <= resp_next;
    end
  end

  always_comb begin
    eri_vec  = '0;
    crit_vec = '0;
    for (int i = 0; i < `RASN_NUM_REC; i++) begin
      eri_vec[i]  = eri_qual(node_control_reg, recs_reg[i]);
      crit_vec[i] = recs_reg[i].valid & recs_reg[i].critical;
    end
  end

  // levels come from stored records and enables, so they hold until software acknowledges, clears the enable or a new error overwrites the record
  always_comb begin
    eri_next  = |eri_vec;
    crit_next = (|crit_vec) & `RASN_FEAT_CI & node_control_reg[`RASN_CTL_CI];
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      eri_irq <= 1'b0;
    end else begin
      eri_irq <= eri_next;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      crit_irq <= 1'b0;
    end else begin
      crit_irq <= crit_next;
    end
  end


endmodule

`default_nettype wire

// *** dv/rasn_node_assertions.sv ***
// port checks for the error reporting node
`timescale 1ns/1ps
`default_nettype none
`include "rasn_regs.svh"
module rasn_node_assertions (
  input wire logic                   clock,
  input wire logic                   arst_n,
  input wire rasn_pkg::rasn_err_t    err_in,
  input wire logic                   ctl_load,
  input wire logic [`RASN_CTL_W-1:0] ctl_data,
  input wire logic [`RASN_REC_W-1:0] rec_rd_idx,
  input wire logic                   rec_clr,
  input wire logic [`RASN_REC_W-1:0] rec_clr_idx,
  input wire logic [`RASN_CTL_W-1:0] node_control_reg,
  input wire logic [`RASN_ID_W-1:0]  node_feature_id_reg,
  input wire rasn_pkg::rasn_rec_t    rec_rd_data,
  input wire rasn_pkg::rasn_resp_t   resp,
  input wire logic                   eri_irq,
  input wire logic                   crit_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire logic [6:0] c = node_control_reg;
  wire logic ue = err_in.valid && err_in.sev == rasn_pkg::RASN_SEV_UE;
  wire logic tc = err_in.valid && err_in.to_consumer;
  sequence s_ue;
    ue && c[0] && c[1] && !err_in.write && !ctl_load;
  endsequence
  sequence s_calm;
    !ctl_load && !rec_clr && !err_in.valid;
  endsequence
  AST_ID: assert property (arst_n |=> node_feature_id_reg == 8'hFF)
    else $error("feature id wrong");
  AST_CTL: assert property (ctl_load |=> c == $past(ctl_data))
    else $error("control not loaded");
  AST_NOAB: assert property (tc && !ue |=> resp.valid && !resp.abort)
    else $error("bad response to non fatal error");
  AST_AB: assert property (tc && ue && !err_in.write && c[5] |=> resp.abort)
    else $error("missing abort");
  AST_ERI_OFF: assert property (c[2:1] == 2'h0 && !ctl_load |=> !eri_irq)
    else $error("recovery irq while disabled");
  AST_CRIT_OFF: assert property (!c[4] && !ctl_load |=> !crit_irq)
    else $error("critical irq while disabled");
  AST_UE_IRQ: assert property (s_ue ##1 s_calm |=> eri_irq)
    else $error("recovery irq missing");
  AST_REC: assert property (err_in.valid && err_in.sev != 2'h0 && c[0] &&
    rec_rd_idx == err_in.rec ##1 $stable(rec_rd_idx) |=> rec_rd_data.valid &&
    rec_rd_data.sev == $past(err_in.sev, 2)) else $error("record not written");
endmodule
bind rasn_node rasn_node_assertions rasn_node_assertions_i (.clock, .arst_n, .err_in,
  .ctl_load, .ctl_data, .rec_rd_idx, .rec_clr, .rec_clr_idx, .node_control_reg,
  .node_feature_id_reg, .rec_rd_data, .resp, .eri_irq, .crit_irq);
`default_nettype wire

// *** dv/rasn_sysctl_model.sv ***
// consumer and system controller stand-in watching the node
`timescale 1ns/1ps
`default_nettype none
module rasn_sysctl_model (
  input  wire logic                 clock,
  input  wire logic                 arst_n,
  input  wire rasn_pkg::rasn_resp_t resp,
  input  wire logic                 crit_irq,
  output var  logic [7:0]           aborts,
  output var  logic                 crit_seen
);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) aborts <= 8'h00;
    else if (resp.valid && resp.abort) aborts <= aborts + 8'h01;
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) crit_seen <= 1'h0;
    else crit_seen <= crit_irq;
  end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// bench driving the error node through its reporting paths
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                 clock = 1'h0;
  logic                 arst_n = 1'h0;
  logic                 ctl_load = 1'h0;
  logic                 rec_clr = 1'h0;
  logic                 rec_clr_idx = 1'h0;
  logic                 rec_rd_idx = 1'h0;
  logic [6:0]           ctl_data = 7'h00;
  rasn_pkg::rasn_err_t  err_in = '0;
  rasn_pkg::rasn_rec_t  rd;
  rasn_pkg::rasn_resp_t resp;
  logic [6:0]           ctl;
  logic [7:0]           fid, aborts;
  logic                 eri_irq, crit_irq, crit_seen;
  logic [31:0]          ts;
  int                   fails = 0;
  int                   check_count = 0;
  rasn_node rasn_node_i (.clock, .arst_n, .err_in, .ctl_load, .ctl_data, .rec_rd_idx,
    .rec_clr, .rec_clr_idx, .node_control_reg(ctl), .node_feature_id_reg(fid),
    .rec_rd_data(rd), .resp, .eri_irq, .crit_irq);
  rasn_sysctl_model rasn_sysctl_model_i (.clock, .arst_n, .resp, .crit_irq, .aborts,
    .crit_seen);
  task automatic chk(input logic [63:0] e, g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic ev(input logic [1:0] s, input logic r, w, c, t, k);
    err_in = '{1'h1, c, t, w, k, rasn_pkg::rasn_sev_t'(s), r, 16'hA5C3};
    cyc(1);
    err_in = '0;
  endtask
  task automatic setc(input logic [6:0] v);
    ctl_load = 1'h1;
    ctl_data = v;
    cyc(1);
    ctl_load = 1'h0;
    cyc(1);
    chk(v, ctl);
  endtask
  task automatic clr(input logic r);
    rec_clr = 1'h1;
    rec_clr_idx = r;
    cyc(1);
    rec_clr = 1'h0;
  endtask
  task automatic rdr(input logic i);
    rec_rd_idx = i;
    cyc(2);
  endtask
  task automatic test_done;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic t_rec;
    setc(7'h07);
    // detected read error then consumed write error, back to back
    for (int i = 0; i < 2; i++) begin
      err_in = '{1'h1, i[0], 1'h0, i[0], 1'h0, rasn_pkg::RASN_SEV_UE, i[0], 16'hA5C3};
      cyc(1);
    end
    err_in = '0;
    cyc(2);
    chk(1'h1, eri_irq);
    rdr(1'h0);
    chk(5'h13, {rd.valid, rd.consumed, rd.write, rd.sev});
    ts = rd.stamp;
    rdr(1'h1);
    chk(5'h1F, {rd.valid, rd.consumed, rd.write, rd.sev});
    chk(ts + 32'h1, rd.stamp);
    // overwrite of a valid record keeps the loss in ovf
    ev(2'h3, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1);
    cyc(1);
    chk(19'h7A5C3, {rd.valid, rd.ovf, rd.critical, rd.syndrome});
    clr(1'h0);
    cyc(3);
    chk(1'h1, eri_irq);
    clr(1'h1);
    cyc(3);
    chk(2'h0, {eri_irq, rd.valid});
    // capture and acknowledge of one record in one cycle: capture wins
    rec_clr = 1'h1;
    rec_clr_idx = 1'h1;
    ev(2'h3, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    rec_clr = 1'h0;
    cyc(1);
    chk(2'h3, {eri_irq, rd.valid});
    clr(1'h1);
    cyc(3);
    $display("t_rec done");
  endtask
  task automatic t_class;
    rdr(1'h0);
    setc(7'h07);
    ev(2'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
    cyc(2);
    chk(2'h0, {eri_irq, crit_irq});
    setc(7'h17);
    cyc(1);
    chk(3'h7, {rd.valid, crit_irq, crit_seen});
    clr(1'h0);
    ev(2'h2, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    cyc(2);
    chk(2'h0, {eri_irq, crit_irq});
    setc(7'h0F);
    chk(1'h1, eri_irq);
    setc(7'h09);
    chk(1'h0, eri_irq);
    setc(7'h00);
    ev(2'h3, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    rdr(1'h1);
    chk(1'h0, rd.valid);
    $display("t_class done");
  endtask
  task automatic t_rsp;
    for (int m = 0; m < 2; m++)
      for (int s = 1; s < 4; s++)
        for (int w = 0; w < 2; w++) begin
          setc(m ? 7'h40 : 7'h20);
          ev(s[1:0], 1'h0, w[0], 1'h0, 1'h1, 1'h0);
          chk({1'h1, s == 3 && w == m}, {resp.valid, resp.abort});
        end
    cyc(1);
    chk(8'h02, aborts);
    $display("t_rsp done");
  endtask
  initial forever #4 clock = ~clock;
  initial begin
    repeat (20) @(negedge clock);
    arst_n = 1'h1;
    cyc(2);
    chk(15'h7F80, {fid, ctl});
    t_rec();
    t_class();
    t_rsp();
    test_done();
  end
  initial begin
    #20000;
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
